/* logic/pend_bank_map.svh */
/*
 Register offsets, field positions and reset values of the pending bank.
 Assumes byte addresses on a 32-bit bus, one aligned word per register.
*/
`ifndef PEND_BANK_MAP_SVH
`define PEND_BANK_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_FORCE_HI 8'h00
`define OFF_DROP_LO 8'h04
`define OFF_DROP_HI 8'h08
`define OFF_EN_HI 8'h0C
`define OFF_EN_LO 8'h10
`define OFF_EVT_STAT 8'h14
`define OFF_EVT_CLR 8'h18
`define OFF_EVT_EN 8'h1C

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define HI_BITS 4
`define LO_BITS 32
`define HI_BASE_IRQ 96
`define EVT_BITS 4
`define EV_FORCED 0
`define EV_FORCE_IGN 1
`define EV_DROP_HELD 2
`define EV_SRC_PEND 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PEND_HI 4'h0
`define RST_PEND_LO 32'h0000_0000
`define RST_EN_HI 4'h0
`define RST_EN_LO 32'h0000_0000
`define RST_EVT 4'h0
`define RST_WORD 32'h0000_0000

`endif

/* logic/pend_bank_pkg.sv */
/*
 Types shared by the pending bank.
 Assumes the map header is included before use of the widths.
*/
`default_nettype none
`include "pend_bank_map.svh"

package pend_bank_pkg;
	typedef logic [`HI_BITS-1:0] hi_vec_type;
	typedef logic [`LO_BITS-1:0] lo_vec_type;
	typedef logic [`EVT_BITS-1:0] evt_vec_type;
	typedef logic [31:0] word_type;
	typedef enum {
		SEL_FORCE_HI,
		SEL_DROP_LO,
		SEL_DROP_HI,
		SEL_EN_HI,
		SEL_EN_LO,
		SEL_EVT_STAT,
		SEL_EVT_CLR,
		SEL_EVT_EN,
		SEL_NONE
	} reg_sel_type;
endpackage

`default_nettype wire

/* logic/irq_set_pending_high_bank.sv */
/*
 Pending-state bank for interrupts 0-31 and 96-99 behind a classic
 Wishbone slave, with a small event status and interrupt output.
 Assumes a single 25 MHz clock, synchronous inputs and that the
 exception logic drives the active (being serviced) flags.
*/
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pend_bank_map.svh"

module irq_set_pending_high_bank
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [`LO_BITS-1:0] src_lo,
	input wire logic [`HI_BITS-1:0] src_hi,
	input wire logic [`LO_BITS-1:0] act_lo,
	input wire logic [`HI_BITS-1:0] act_hi,
	output logic [`LO_BITS-1:0] pend_lo,
	output logic [`HI_BITS-1:0] pend_hi,
	output logic irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic pend_bank_pkg::reg_sel_type decode(
		input logic [7:0] adr
	);
		logic [7:0] a;
		a = {adr[7:2], 2'h0};
		if (a == `OFF_FORCE_HI)
			decode = pend_bank_pkg::SEL_FORCE_HI;
		else if (a == `OFF_DROP_LO)
			decode = pend_bank_pkg::SEL_DROP_LO;
		else if (a == `OFF_DROP_HI)
			decode = pend_bank_pkg::SEL_DROP_HI;
		else if (a == `OFF_EN_HI)
			decode = pend_bank_pkg::SEL_EN_HI;
		else if (a == `OFF_EN_LO)
			decode = pend_bank_pkg::SEL_EN_LO;
		else if (a == `OFF_EVT_STAT)
			decode = pend_bank_pkg::SEL_EVT_STAT;
		else if (a == `OFF_EVT_CLR)
			decode = pend_bank_pkg::SEL_EVT_CLR;
		else if (a == `OFF_EVT_EN)
			decode = pend_bank_pkg::SEL_EVT_EN;
		else
			decode = pend_bank_pkg::SEL_NONE;
	endfunction

	// Byte enables widened to a bit mask
	function automatic pend_bank_pkg::word_type lane_mask(
		input logic [3:0] sel
	);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// A drop only lands where the interrupt is not being serviced
	function automatic pend_bank_pkg::lo_vec_type drop_ok(
		input pend_bank_pkg::lo_vec_type drop,
		input pend_bank_pkg::lo_vec_type act
	);
		drop_ok = drop & ~act;
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	pend_bank_pkg::reg_sel_type cur_sel;
	pend_bank_pkg::word_type wmask;
	pend_bank_pkg::word_type wdat;
	logic ack_r;
	logic ack_nxt;
	logic bus_start;
	logic wr_fire;
	pend_bank_pkg::word_type dat_r;
	pend_bank_pkg::word_type dat_nxt;

	assign cur_sel = decode(wb_adr_i);
	assign wmask = lane_mask(wb_sel_i);
	assign wdat = wb_dat_i & wmask;
	assign bus_start = wb_cyc_i & wb_stb_i & ~ack_r;
	// Writes land on the edge where the master sees ack
	assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	pend_bank_pkg::hi_vec_type pend_hi_r;
	pend_bank_pkg::hi_vec_type pend_hi_nxt;
	pend_bank_pkg::lo_vec_type pend_lo_r;
	pend_bank_pkg::lo_vec_type pend_lo_nxt;
	pend_bank_pkg::hi_vec_type en_hi_r;
	pend_bank_pkg::hi_vec_type en_hi_nxt;
	pend_bank_pkg::lo_vec_type en_lo_r;
	pend_bank_pkg::lo_vec_type en_lo_nxt;
	pend_bank_pkg::evt_vec_type evt_r;
	pend_bank_pkg::evt_vec_type evt_nxt;
	pend_bank_pkg::evt_vec_type evt_en_r;
	pend_bank_pkg::evt_vec_type evt_en_nxt;

	pend_bank_pkg::hi_vec_type force_hi;
	pend_bank_pkg::hi_vec_type drop_hi;
	pend_bank_pkg::lo_vec_type drop_lo;
	pend_bank_pkg::evt_vec_type evt_set;
	pend_bank_pkg::evt_vec_type evt_clr;

	// only bits 3-0 reach the state
	assign force_hi = (wr_fire && cur_sel == pend_bank_pkg::SEL_FORCE_HI)
		? wdat[`HI_BITS-1:0] : `RST_PEND_HI;
	assign drop_hi = (wr_fire && cur_sel == pend_bank_pkg::SEL_DROP_HI)
		? wdat[`HI_BITS-1:0] : `RST_PEND_HI;
	// drop bit n is interrupt n
	assign drop_lo = (wr_fire && cur_sel == pend_bank_pkg::SEL_DROP_LO)
		? wdat : `RST_PEND_LO;
	assign evt_clr = (wr_fire && cur_sel == pend_bank_pkg::SEL_EVT_CLR)
		? wdat[`EVT_BITS-1:0] : `RST_EVT;

	always_comb
	begin
		evt_set = `RST_EVT;
		evt_set[`EV_FORCED] = |(force_hi & en_hi_r & ~pend_hi_r);
		evt_set[`EV_FORCE_IGN] = |(force_hi & ~(en_hi_r & ~pend_hi_r));
		evt_set[`EV_DROP_HELD] = |(drop_lo & act_lo) |
			|(drop_hi & act_hi);
		evt_set[`EV_SRC_PEND] = |(src_lo & en_lo_r & ~pend_lo_r) |
			|(src_hi & en_hi_r & ~pend_hi_r);
	end

	// Pending flags: one shared flag per interrupt for both views
	always_comb
	begin
		// serviced interrupts and zero bits keep their state
		pend_lo_nxt = pend_lo_r & ~drop_ok(drop_lo, act_lo);
		// a drop of one clears the shared flag unless the interrupt is serviced
		pend_hi_nxt = pend_hi_r &
			~(drop_hi & ~act_hi);
		// force of one pends an enabled interrupt
		// disabled bits take no pend; pending ones stay
		// zero bits leave the flag alone
		pend_hi_nxt = pend_hi_nxt | (force_hi & en_hi_r);
		// Sources win over a drop in the same cycle
		pend_lo_nxt = pend_lo_nxt | (src_lo & en_lo_r);
		pend_hi_nxt = pend_hi_nxt | (src_hi & en_hi_r);
	end

	always_comb
	begin
		en_hi_nxt = en_hi_r;
		en_lo_nxt = en_lo_r;
		evt_en_nxt = evt_en_r;
		if (wr_fire && cur_sel == pend_bank_pkg::SEL_EN_HI)
			en_hi_nxt = (en_hi_r & ~wmask[`HI_BITS-1:0]) |
				wdat[`HI_BITS-1:0];
		else if (wr_fire && cur_sel == pend_bank_pkg::SEL_EN_LO)
			en_lo_nxt = (en_lo_r & ~wmask) | wdat;
		else if (wr_fire && cur_sel == pend_bank_pkg::SEL_EVT_EN)
			evt_en_nxt = (evt_en_r & ~wmask[`EVT_BITS-1:0]) |
				wdat[`EVT_BITS-1:0];
		// Set wins over clear so no event is lost
		evt_nxt = (evt_r & ~evt_clr) | evt_set;
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	always_comb
	begin
		ack_nxt = bus_start;
		dat_nxt = dat_r;
		if (bus_start)
		begin
			dat_nxt = `RST_WORD;
			case (cur_sel)
				pend_bank_pkg::SEL_FORCE_HI:
					dat_nxt[`HI_BITS-1:0] = pend_hi_r;
				pend_bank_pkg::SEL_DROP_LO:
					dat_nxt = pend_lo_r;
				pend_bank_pkg::SEL_DROP_HI:
					dat_nxt[`HI_BITS-1:0] = pend_hi_r;
				pend_bank_pkg::SEL_EN_HI:
					dat_nxt[`HI_BITS-1:0] = en_hi_r;
				pend_bank_pkg::SEL_EN_LO:
					dat_nxt = en_lo_r;
				pend_bank_pkg::SEL_EVT_STAT:
					dat_nxt[`EVT_BITS-1:0] = evt_r;
				pend_bank_pkg::SEL_EVT_EN:
					dat_nxt[`EVT_BITS-1:0] = evt_en_r;
				default:
					dat_nxt = `RST_WORD;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ack_r <= 1'b0;
			dat_r <= `RST_WORD;
			pend_hi_r <= `RST_PEND_HI;
			pend_lo_r <= `RST_PEND_LO;
			en_hi_r <= `RST_EN_HI;
			en_lo_r <= `RST_EN_LO;
			evt_r <= `RST_EVT;
			evt_en_r <= `RST_EVT;
		end
		else
		begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			pend_hi_r <= pend_hi_nxt;
			pend_lo_r <= pend_lo_nxt;
			en_hi_r <= en_hi_nxt;
			en_lo_r <= en_lo_nxt;
			evt_r <= evt_nxt;
			evt_en_r <= evt_en_nxt;
		end
	end

	assign pend_hi = pend_hi_r;
	assign pend_lo = pend_lo_r;
	assign irq = |(evt_r & evt_en_r);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_force_sets: assert property (
		(|(force_hi & en_hi_r)) |=>
		((pend_hi_r & $past(force_hi & en_hi_r)) ==
		$past(force_hi & en_hi_r)))
		else $error("forced interrupt not pending");

	a_disabled_hold: assert property (
		((|force_hi) && !(|src_hi)) |=>
		((pend_hi_r & ~$past(en_hi_r)) ==
		($past(pend_hi_r) & ~$past(en_hi_r))))
		else $error("disabled interrupt changed on force");

	a_force_no_drop: assert property (
		((|force_hi) && !(|drop_hi)) |=>
		(($past(pend_hi_r) & ~pend_hi_r) == 4'h0))
		else $error("force write dropped a pend");

	a_read_live: assert property (
		(bus_start && !wb_we_i &&
		cur_sel == pend_bank_pkg::SEL_FORCE_HI) |=>
		(wb_ack_o && wb_dat_o[3:0] == $past(pend_hi_r)))
		else $error("read does not show pending state");

	a_drop_clears: assert property (
		((|drop_hi) && !(|src_hi)) |=>
		((pend_hi_r & $past(drop_hi & ~act_hi)) == 4'h0))
		else $error("drop did not clear pend");

	a_bit_mapping: assert property (
		((|force_hi) && !(|src_hi)) |=>
		(((pend_hi_r ^ $past(pend_hi_r)) & ~$past(force_hi)) == 4'h0))
		else $error("force touched another interrupt");

	a_low_drop: assert property (
		((|drop_lo) && !(|src_lo)) |=>
		((pend_lo_r & $past(drop_ok(drop_lo, act_lo))) == 32'h0))
		else $error("low drop did not clear pend");

	a_active_kept: assert property (
		(|(drop_lo & act_lo)) |=>
		((pend_lo_r & $past(drop_lo & act_lo)) ==
		$past(pend_lo_r & drop_lo & act_lo)))
		else $error("serviced interrupt was dropped");

	a_upper_zero: assert property (
		(wb_ack_o && !wb_we_i &&
		cur_sel == pend_bank_pkg::SEL_FORCE_HI) |->
		(wb_dat_o[31:4] == 28'h0000000))
		else $error("upper force bits not zero");

	a_irq_level: assert property (
		((|(evt_set & evt_en_r)) &&
		!(wr_fire && cur_sel == pend_bank_pkg::SEL_EVT_EN)) |=> irq)
		else $error("interrupt output low while enabled event set");

	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held beyond one cycle");

	a_ack_answer: assert property (
		bus_start |=> wb_ack_o)
		else $error("request not answered in one cycle");

	a_src_pends: assert property (
		(|(src_lo & en_lo_r)) |=>
		((pend_lo_r & $past(src_lo & en_lo_r)) ==
		$past(src_lo & en_lo_r)))
		else $error("enabled source did not pend");

	a_evt_sticky: assert property (
		(|evt_set) |=>
		((evt_r & $past(evt_set)) == $past(evt_set)))
		else $error("event set lost");

	a_upper_discard: assert property (
		(wr_fire && cur_sel == pend_bank_pkg::SEL_FORCE_HI &&
		wdat[`HI_BITS-1:0] == 4'h0 && !(|src_hi)) |=>
		$stable(pend_hi_r))
		else $error("upper force bits changed pending state");

	a_hi_active_kept: assert property (
		(|(drop_hi & act_hi)) |=>
		((pend_hi_r & $past(drop_hi & act_hi)) ==
		$past(pend_hi_r & drop_hi & act_hi)))
		else $error("serviced high interrupt was dropped");

	// Clearing an enable only gates new pends
	a_en_keeps_pend: assert property (
		(wr_fire && cur_sel == pend_bank_pkg::SEL_EN_LO &&
		!(|src_lo)) |=> $stable(pend_lo_r))
		else $error("enable write changed pending state");

endmodule

`default_nettype wire

/* testbench/irq_set_pending_high_bank_bench.sv */
/*
 Self-checking bench for the pending bank, with a reference model.
 Assumes one 25 MHz clock, a synchronous active-low reset and a
 classic Wishbone slave that answers every access.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pend_bank_map.svh"
module irq_set_pending_high_bank_bench;
	logic clk, rstn, cyc, stb, we, ack, irq;
	logic [7:0] adr;
	logic [3:0] sel, src_hi, act_hi, pend_hi;
	logic [31:0] dat_i, dat_o, src_lo, act_lo, pend_lo;
	logic [31:0] m_plo, m_elo;
	logic [3:0] m_phi, m_ehi, m_ev, m_eve;
	int error_cnt, cmp_count;

	irq_set_pending_high_bank dut
	(
		.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .src_lo(src_lo),
		.src_hi(src_hi), .act_lo(act_lo), .act_hi(act_hi),
		.pend_lo(pend_lo), .pend_hi(pend_hi), .irq(irq)
	);

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic cmp(input logic [35:0] g, input logic [35:0] e,
		input string what);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
		end
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] g);
		logic [31:0] e;
		case (a)
			`OFF_FORCE_HI, `OFF_DROP_HI: e = {28'h0, m_phi};
			`OFF_DROP_LO: e = m_plo;
			`OFF_EN_HI: e = {28'h0, m_ehi};
			`OFF_EN_LO: e = m_elo;
			`OFF_EVT_STAT: e = {28'h0, m_ev};
			`OFF_EVT_EN: e = {28'h0, m_eve};
			default: e = 32'h0000_0000;
		endcase
		cmp({4'h0, g}, {4'h0, e}, "read data");
	endtask
	task automatic chk_pend();
		cmp({pend_hi, pend_lo}, {m_phi, m_plo}, "pending flags");
		cmp({35'h0, irq}, {35'h0, |(m_ev & m_eve)}, "interrupt line");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Bus master and model update
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		// Slave must have dropped ack before a new request
		cmp({35'h0, ack}, 36'h0, "ack idle before request");
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_i <= d;
		// Only the watchdog ends a wait that never gets an answer
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] q, lm, m;
		lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		m = d & lm;
		wb(1'b1, a, s, d, q);
		case (a)
			`OFF_FORCE_HI:
				for (int i = 0; i < 4; i++)
					if (m[i])
					begin
						if (m_ehi[i] && !m_phi[i])
						begin
							m_phi[i] = 1'b1;
							m_ev[0] = 1'b1;
						end
						else
							m_ev[1] = 1'b1;
					end
			`OFF_DROP_LO:
			begin
				m_ev[2] = m_ev[2] | (|(m & act_lo));
				m_plo = m_plo & ~(m & ~act_lo);
			end
			`OFF_DROP_HI:
			begin
				m_ev[2] = m_ev[2] | (|(m[3:0] & act_hi));
				m_phi = m_phi & ~(m[3:0] & ~act_hi);
			end
			`OFF_EN_HI: m_ehi = (m_ehi & ~lm[3:0]) | m[3:0];
			`OFF_EN_LO: m_elo = (m_elo & ~lm) | m;
			`OFF_EVT_CLR: m_ev = m_ev & ~m[3:0];
			`OFF_EVT_EN: m_eve = (m_eve & ~lm[3:0]) | m[3:0];
			default: ;
		endcase
	endtask
	task automatic read_all();
		logic [31:0] q;
		@(posedge clk);
		chk_pend();
		for (int a = 0; a <= 32; a += 4)
		begin
			wb(1'b0, a[7:0], 4'hF, 32'h0000_0000, q);
			chk_rd(a[7:0], q);
		end
	endtask
	task automatic pulse(input logic [31:0] l, input logic [3:0] h);
		@(posedge clk);
		src_lo <= l;
		src_hi <= h;
		@(posedge clk);
		src_lo <= 32'h0000_0000;
		src_hi <= 4'h0;
		if (|(l & m_elo & ~m_plo) || |(h & m_ehi & ~m_phi))
			m_ev[3] = 1'b1;
		m_plo = m_plo | (l & m_elo);
		m_phi = m_phi | (h & m_ehi);
	endtask
	task automatic mreset();
		{m_plo, m_elo, m_phi, m_ehi, m_ev, m_eve} = '0;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
	initial
	begin
		{rstn, cyc, stb, we, adr, sel, dat_i} = '0;
		{src_lo, src_hi, act_lo, act_hi} = '0;
		error_cnt = 0;
		cmp_count = 0;
		mreset();
		void'($urandom(32'h3AAB8552));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		read_all();
		wr(`OFF_EN_HI, $urandom, 4'hF);
		wr(`OFF_EN_LO, $urandom, 4'hF);
		for (int k = 0; k < 12; k++)
		begin
			wr(`OFF_EVT_EN, k, 4'hF);
			pulse($urandom, 4'($urandom));
			// lane 0 masked in some rounds
			wr(`OFF_FORCE_HI, $urandom, (k % 3 == 0) ? 4'hE : 4'hF);
			act_lo <= $urandom & m_plo;
			act_hi <= 4'($urandom) & m_phi;
			wr(`OFF_DROP_LO, $urandom, 4'($urandom));
			wr(`OFF_DROP_HI, $urandom, 4'hF);
			if (k == 6)
				wr(`OFF_EN_HI, $urandom, 4'hF);
			wr(`OFF_EVT_STAT, 32'hFFFF_FFFF, 4'hF);
			wr(`OFF_EVT_CLR, $urandom, 4'hF);
			read_all();
		end
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		mreset();
		read_all();
		wrap_up();
	end
endmodule
`default_nettype wire
